// ---- rtl/cbr_chain_slave.sv ----
// Purpose: chained block readout slave with header, data and trailer
// Assumes: data source on clk_i, backplane strobes asynchronous
// Notes: registers over classic Wishbone, one ack per request
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module cbr_chain_slave #(
  parameter int DATA_W = 32,
  parameter longint LED_HOLD_CYC = cbr_pkg::LED_HOLD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone register port
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // backplane
  input wire logic vme_as_n_i,
  input wire logic vme_ds_n_i,
  input wire logic vme_write_n_i,
  input wire logic [5:0] vme_am_i,
  input wire logic [7:0] vme_addr_hi_i,
  input wire logic vme_token_in_n_i,
  output logic vme_token_out_n_o,
  output logic [31:0] vme_data_o,
  output logic vme_data_oe_o,
  output logic vme_dtack_n_o,
  output logic vme_dtack_oe_o,
  output logic vme_berr_n_o,
  output logic vme_berr_oe_o,
  input wire logic sysreset_n_i,
  // jumpers
  input wire logic sysreset_behaviour_jumper_i,
  input wire logic [cbr_pkg::BOOT_W-1:0] boot_select_jumpers_i,
  output logic [cbr_pkg::BOOT_W-1:0] boot_select_o,
  // event data source
  input wire logic [DATA_W-1:0] data_i,
  input wire logic data_valid_i,
  output logic data_ready_o,
  output logic access_led_o
);

  // twenty backplane and jumper bits plus the boot array
  localparam int SW = 20 + cbr_pkg::BOOT_W;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  logic [SW-1:0] pins;
  logic [SW-1:0] pins_s;
  logic as_n;
  logic ds_n;
  logic write_n;
  logic [5:0] am;
  logic [7:0] addr_hi;
  logic token_in_n;
  logic sysreset_n;
  logic jumper_open;
  logic [cbr_pkg::BOOT_W-1:0] boot_s;

  assign pins = {boot_select_jumpers_i, sysreset_behaviour_jumper_i,
                 sysreset_n_i, vme_token_in_n_i, vme_addr_hi_i, vme_am_i,
                 vme_write_n_i, vme_ds_n_i, vme_as_n_i};
  assign {boot_s, jumper_open, sysreset_n, token_in_n, addr_hi, am,
          write_n, ds_n, as_n} = pins_s;

  cbr_pin_sync #(
    .W(SW),
    .INIT({SW{1'b1}})
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pins),
    .sync_o(pins_s)
  );

  // closed jumper pulls its pin low; key reset on system reset then
  logic key_rst;
  assign key_rst = rst_i || (!jumper_open && !sysreset_n); // RQ13

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] setup_r;
  logic [cbr_pkg::BYTE_CNT_W-1:0] byte_cnt_r;
  logic [cbr_pkg::BOOT_W-1:0] boot_r;
  cbr_pkg::cbr_state_e state_r;
  logic led_r;
  logic ack_r;
  logic [31:0] rd_dat_r;

  logic enable;
  logic is_last;
  logic is_first;
  logic [cbr_pkg::GEO_W-1:0] geo;
  logic [cbr_pkg::ADDR_W-1:0] chain_addr;

  assign enable = setup_r[cbr_pkg::SET_ENABLE];
  assign is_last = setup_r[cbr_pkg::SET_LAST];
  assign is_first = setup_r[cbr_pkg::SET_FIRST];
  assign geo = setup_r[cbr_pkg::SET_GEO_LSB +: cbr_pkg::GEO_W];
  assign chain_addr = setup_r[cbr_pkg::SET_ADDR_LSB +: cbr_pkg::ADDR_W];

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  logic wb_req;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_dat_r;

  always_ff @(posedge clk_i) begin
    if (key_rst) begin
      setup_r <= cbr_pkg::SETUP_RESET;
    end else if (wb_req && wb_we_i && wb_adr_i == cbr_pkg::REG_SETUP) begin
      setup_r <= merge_bytes(setup_r, wb_dat_i, wb_sel_i) &
                 cbr_pkg::SETUP_MASK; // RQ16
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_dat_r <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      rd_dat_r <= 32'h0000_0000;
      case (wb_adr_i)
        cbr_pkg::REG_SETUP: begin
          rd_dat_r <= setup_r;
        end
        cbr_pkg::REG_STATUS: begin
          rd_dat_r[cbr_pkg::STAT_STATE_LSB +: 7] <= state_r;
          rd_dat_r[cbr_pkg::STAT_TOKEN] <= !token_in_n;
          rd_dat_r[cbr_pkg::STAT_JUMPER] <= !jumper_open;
          rd_dat_r[cbr_pkg::STAT_LED] <= led_r;
          rd_dat_r[cbr_pkg::STAT_BOOT_LSB +: cbr_pkg::BOOT_W] <= boot_r;
        end
        cbr_pkg::REG_COUNT: begin
          rd_dat_r[cbr_pkg::BYTE_CNT_W-1:0] <= byte_cnt_r;
        end
        default: begin
          rd_dat_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  // boot array: open reads one, bit 0 sits nearest the P2 connector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_r <= '1;
    end else begin
      boot_r <= boot_s; // RQ14
    end
  end
  assign boot_select_o = boot_r;

  ////////////////////////////////////////////////////////////////////////
  // chained readout engine

  logic selected;
  logic [1:0] stage_r;
  logic beat;
  logic word_state;
  logic take_data;

  // only A32 block modifiers; single cycle reads are never answered
  assign selected = !as_n && write_n && enable && // RQ3
                    addr_hi == chain_addr && // RQ1
                    (am == cbr_pkg::AM_A32_BLT_USER ||
                     am == cbr_pkg::AM_A32_BLT_SUPER); // RQ8 RQ15

  assign word_state = state_r == cbr_pkg::ST_HEADER ||
                      state_r == cbr_pkg::ST_DATA;
  assign beat = word_state && !ds_n && stage_r == 2'd0;
  assign take_data = beat && state_r == cbr_pkg::ST_DATA && data_valid_i;
  assign data_ready_o = take_data;

  function automatic logic [31:0] header_word(
      input logic [cbr_pkg::GEO_W-1:0] g);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[cbr_pkg::WORD_GEO_LSB +: cbr_pkg::GEO_W] = g;
    return w;
  endfunction

  logic [cbr_pkg::BYTE_CNT_W-1:0] trailer_cnt;
  assign trailer_cnt = byte_cnt_r + cbr_pkg::BYTES_PER_WORD;

  always_ff @(posedge clk_i) begin
    if (key_rst) begin
      state_r <= cbr_pkg::ST_IDLE;
    end else if (as_n) begin
      // strobe released: anything unfinished restarts at the first module
      state_r <= cbr_pkg::ST_IDLE; // RQ9
    end else begin
      case (state_r)
        cbr_pkg::ST_IDLE: begin
          if (selected) begin
            state_r <= cbr_pkg::ST_WAIT_TOKEN;
          end
        end
        cbr_pkg::ST_WAIT_TOKEN: begin
          if (is_first || !token_in_n) begin
            state_r <= cbr_pkg::ST_HEADER;
          end
        end
        cbr_pkg::ST_HEADER: begin
          if (beat) begin
            state_r <= cbr_pkg::ST_DATA;
          end
        end
        cbr_pkg::ST_DATA: begin
          if (beat && !data_valid_i) begin
            state_r <= cbr_pkg::ST_DONE;
          end
        end
        cbr_pkg::ST_DONE: begin
          // wait for the trailer beat to finish before handing over
          if (stage_r == 2'd0) begin
            state_r <= is_last ? cbr_pkg::ST_BERR : cbr_pkg::ST_PASS;
          end
        end
        cbr_pkg::ST_PASS: begin
          state_r <= cbr_pkg::ST_PASS;
        end
        cbr_pkg::ST_BERR: begin
          state_r <= cbr_pkg::ST_BERR;
        end
        default: begin
          state_r <= cbr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // beat stages: 0 waiting, 1 data driven, 2 acknowledge until strobe rises
  always_ff @(posedge clk_i) begin
    if (key_rst || as_n) begin
      stage_r <= 2'd0;
    end else begin
      case (stage_r)
        2'd0: begin
          if (beat) begin
            stage_r <= 2'd1;
          end
        end
        2'd1: begin
          stage_r <= 2'd2;
        end
        2'd2: begin
          if (ds_n) begin
            stage_r <= 2'd0;
          end
        end
        default: begin
          stage_r <= 2'd0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (key_rst) begin
      vme_data_o <= 32'h0000_0000;
    end else if (beat) begin
      if (state_r == cbr_pkg::ST_HEADER) begin
        vme_data_o <= header_word(geo); // RQ7 RQ17
      end else if (data_valid_i) begin
        vme_data_o <= data_i;
      end else begin
        vme_data_o <= header_word(geo) |
                      {5'h00, trailer_cnt}; // RQ7 RQ17
      end
    end
  end

  // bytes moved by this module, header and trailer included
  always_ff @(posedge clk_i) begin
    if (key_rst) begin
      byte_cnt_r <= '0;
    end else if (state_r == cbr_pkg::ST_WAIT_TOKEN) begin
      byte_cnt_r <= '0;
    end else if (beat) begin
      byte_cnt_r <= trailer_cnt;
    end
  end

  assign vme_data_oe_o = stage_r != 2'd0;
  assign vme_dtack_n_o = 1'b0;
  assign vme_dtack_oe_o = stage_r == 2'd2;

  // bus error only while the strobe is down, so each beat sees one edge
  assign vme_berr_n_o = 1'b0;
  assign vme_berr_oe_o = state_r == cbr_pkg::ST_BERR && !ds_n; // RQ6

  // token stays with the next module until the address strobe rises
  always_ff @(posedge clk_i) begin
    if (key_rst) begin
      vme_token_out_n_o <= 1'b1;
    end else begin
      vme_token_out_n_o <= !(state_r == cbr_pkg::ST_PASS && !as_n); // RQ5
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // access indicator, stretched so a short transfer stays visible

  logic [63:0] led_cnt_r;

  always_ff @(posedge clk_i) begin
    if (key_rst) begin
      led_cnt_r <= 64'h0;
      led_r <= 1'b0;
    end else if (beat && state_r == cbr_pkg::ST_HEADER) begin
      led_cnt_r <= 64'(LED_HOLD_CYC); // RQ12
      led_r <= 1'b1; // RQ12
    end else if (led_cnt_r != 64'h0) begin
      led_cnt_r <= led_cnt_r - 64'h1;
      led_r <= led_cnt_r != 64'h1;
    end
  end
  assign access_led_o = led_r;

endmodule

`default_nettype wire

// ---- rtl/cbr_pin_sync.sv ----
// Purpose: three-stage synchroniser for a group of backplane pins
// Assumes: pins are asynchronous to clk_i
// Notes: a bit changes its output only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module cbr_pin_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // the filter looks at stages two and three only, never at the first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_o <= INIT;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          sync_o[i] <= s3_r[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- shared/cbr_pkg.sv ----
// Behaviour
// RQ1 - chained address equals setup register bits 31..24, same on every module.
// RQ2 - software marks the module nearest the CPU first, the far one last.
// RQ3 - only modules with the chained enable bit set take part.
// RQ4 - participating modules sit in adjacent slots so the token path is unbroken.
// RQ5 - when its data are exhausted a module passes the token down the daisy chain.
// RQ6 - the last module ends the transfer with a bus error after its data.
// RQ7 - header before data, trailer after; both carry the geographical identifier.
// RQ8 - answer the chained address only for block transfer modifiers, not single reads.
// RQ9 - a transfer cut short restarts from the first module on the next access.
// RQ10 - master reads the whole chain in one block or splits it into chains.
// RQ11 - master may request maximum length and use bus error plus byte count.
// RQ12 - access indicator turns on when the header word goes on the bus.
// RQ13 - with the reset jumper closed, backplane system reset causes a key reset.
// RQ14 - boot jumper array reads open as one, bit 0 nearest the P2 connector.
// RQ15 - modifier 0x0B (A32 non-privileged block) selects a chained block read.
// RQ16 - setup: bit0 enable, bit1 last, bit2 first, id from bit 11, address 31..24.
// RQ17 - header id at bit 27, low bits zero; trailer adds the byte count below.
//
// Purpose: shared constants of the chained block readout slave
// Assumes: 100 MHz clock, classic Wishbone register port
// Notes: all offsets are byte addresses of aligned 32-bit words
`default_nettype none

package cbr_pkg;

  // register map
  localparam logic [3:0] REG_SETUP = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h8;
  localparam logic [31:0] SETUP_RESET = 32'h0000_0000;
  localparam logic [31:0] SETUP_MASK = 32'hFF00_F807;

  // setup register fields
  localparam int SET_ENABLE = 0;
  localparam int SET_LAST = 1;
  localparam int SET_FIRST = 2;
  localparam int SET_GEO_LSB = 11;
  localparam int GEO_W = 5;
  localparam int SET_ADDR_LSB = 24;
  localparam int ADDR_W = 8;

  // output word layout
  localparam int WORD_GEO_LSB = 27;
  localparam int BYTE_CNT_W = 27;
  localparam logic [BYTE_CNT_W-1:0] BYTES_PER_WORD = 27'h4;

  // status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_TOKEN = 8;
  localparam int STAT_JUMPER = 9;
  localparam int STAT_LED = 10;
  localparam int STAT_BOOT_LSB = 12;

  // block transfer modifiers, A32 non-privileged and supervisory
  localparam logic [5:0] AM_A32_BLT_USER = 6'h0B;
  localparam logic [5:0] AM_A32_BLT_SUPER = 6'h0F;

  localparam int BOOT_W = 4;

  // timing
  localparam longint CLK_HZ = 100_000_000;
  localparam longint LED_HOLD_MS = 50;
  localparam longint LED_HOLD_CYC = (LED_HOLD_MS * CLK_HZ) / 1000;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_WAIT_TOKEN = 7'b000_0010,
    ST_HEADER = 7'b000_0100,
    ST_DATA = 7'b000_1000,
    ST_PASS = 7'b001_0000,
    ST_BERR = 7'b010_0000,
    ST_DONE = 7'b100_0000
  } cbr_state_e;

endpackage

`default_nettype wire

// ---- testbench/cbr_chain_slave_assertions.sv ----
// Purpose: protocol checks on the chained readout slave
// Assumes: bound to cbr_chain_slave, single clock
// Notes: pin figures allow for the input synchroniser
`timescale 1ns/1ps
`default_nettype none
module cbr_chain_slave_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic vme_as_n_i,
  input wire logic vme_write_n_i,
  input wire logic [5:0] vme_am_i,
  input wire logic vme_token_out_n_o,
  input wire logic vme_data_oe_o,
  input wire logic vme_dtack_oe_o,
  input wire logic vme_berr_oe_o,
  input wire logic [3:0] boot_select_jumpers_i,
  input wire logic [3:0] boot_select_o,
  input wire logic access_led_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_ack1;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack1: assert property (p_ack1) else $error("long ack");
  property p_mod;
    $rose(vme_data_oe_o) |->
      vme_write_n_i && (vme_am_i == 6'h0B || vme_am_i == 6'h0F);
  endproperty
  a_mod: assert property (p_mod) else $error("bad cycle");
  property p_dtk;
    $rose(vme_dtack_oe_o) |-> $past(vme_data_oe_o) && vme_data_oe_o;
  endproperty
  a_dtk: assert property (p_dtk) else $error("early dtack");
  property p_berr;
    vme_berr_oe_o |-> !vme_data_oe_o && !vme_dtack_oe_o;
  endproperty
  a_berr: assert property (p_berr) else $error("berr clash");
  property p_led;
    $rose(access_led_o) |-> vme_data_oe_o;
  endproperty
  a_led: assert property (p_led) else $error("led off bus");
  property p_tok;
    $fell(vme_token_out_n_o) |-> !vme_as_n_i;
  endproperty
  a_tok: assert property (p_tok) else $error("stray token");
  property p_rel;
    $rose(vme_as_n_i) |-> ##[1:12]
      (vme_token_out_n_o && !vme_berr_oe_o && !vme_data_oe_o);
  endproperty
  a_rel: assert property (p_rel) else $error("no release");
  property p_boot;
    $stable(boot_select_jumpers_i) [*8] |->
      boot_select_o == boot_select_jumpers_i;
  endproperty
  a_boot: assert property (p_boot) else $error("boot");
  c_berr: cover property (vme_berr_oe_o);
  c_tok: cover property ($fell(vme_token_out_n_o));
  c_led: cover property ($rose(access_led_o));
endmodule
bind cbr_chain_slave cbr_chain_slave_assertions u_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .vme_as_n_i,
  .vme_write_n_i, .vme_am_i, .vme_token_out_n_o, .vme_data_oe_o,
  .vme_dtack_oe_o, .vme_berr_oe_o, .boot_select_jumpers_i,
  .boot_select_o, .access_led_o);
`default_nettype wire

// ---- testbench/cbr_vme_master.sv ----
// Purpose: backplane master model issuing block reads
// Assumes: slave outputs settle on clk_i
// Notes: strobes move only just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module cbr_vme_master (
  input wire logic clk_i,
  input wire logic [31:0] data_i,
  input wire logic dtack_oe_i,
  input wire logic berr_oe_i,
  output logic as_n_o,
  output logic ds_n_o,
  output logic write_n_o,
  output logic [5:0] am_o,
  output logic [7:0] adr_o
);
  initial begin
    as_n_o = 1'b1;
    ds_n_o = 1'b1;
    write_n_o = 1'b1;
    am_o = 6'h0B;
    adr_o = 8'h00;
  end
  ////////////////////////////////////////
  task automatic start(input logic [5:0] am, input logic [7:0] a,
                       input logic wn);
    @(posedge clk_i);
    am_o <= am;
    adr_o <= a;
    write_n_o <= wn;
    as_n_o <= 1'b0;
  endtask
  // whole chain in one block; an early stop cuts it short
  task automatic stop();
    @(posedge clk_i);
    as_n_o <= 1'b1;
    adr_o <= ~adr_o;
    repeat (12) @(posedge clk_i);
  endtask
  // r: 0 silent, 1 data, 2 bus error ends an unknown length
  task automatic beat(input int gap, output logic [1:0] r,
                      output logic [31:0] d);
    int n;
    r = 2'h0;
    d = 32'h0;
    @(posedge clk_i);
    ds_n_o <= 1'b0;
    for (n = 0; n < 40 && r == 2'h0; n++) begin
      @(posedge clk_i);
      if (dtack_oe_i === 1'b1) begin
        r = 2'h1;
        d = data_i;
      end else if (berr_oe_i === 1'b1) begin
        r = 2'h2;
      end
    end
    ds_n_o <= 1'b1;
    repeat (gap) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ---- testbench/test_chained_block_readout.sv ----
// Purpose: self-checking bench of the chained readout slave
// Assumes: 100 MHz clock, pins driven after rising edges
// Notes: led stretch shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module test_chained_block_readout;
  logic clk_i, rst_i, cyc, we, ack, sr_n, jp, tok_n, tok_o, led, rdy;
  logic as_n, ds_n, wn, dtk, ber, dv;
  logic [3:0] adr, boot, bsel;
  logic [5:0] am;
  logic [7:0] ahi;
  logic [31:0] wdat, rdat, vdat, din, rd;
  int fails, check_count, left, i, k;
  logic [67:0] rows [5] = '{{4'h0, 32'hFFFFFFFF, 32'hFF00F807},
    {4'h0, 32'h45000807, 32'h45000807}, {4'h8, 32'hFFFFFFFF, 32'h0},
    {4'hC, 32'hFFFFFFFF, 32'h0}, {4'h4, 32'hFFFFFFFF, 32'h0000A001}};
  assign dv = left != 0;
  cbr_chain_slave #(.LED_HOLD_CYC(20)) dut (.clk_i, .rst_i,
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .vme_as_n_i(as_n), .vme_ds_n_i(ds_n), .vme_write_n_i(wn),
    .vme_am_i(am), .vme_addr_hi_i(ahi), .vme_token_in_n_i(tok_n),
    .vme_token_out_n_o(tok_o), .vme_data_o(vdat), .vme_data_oe_o(),
    .vme_dtack_n_o(), .vme_dtack_oe_o(dtk), .vme_berr_n_o(),
    .vme_berr_oe_o(ber), .sysreset_n_i(sr_n),
    .sysreset_behaviour_jumper_i(jp), .boot_select_jumpers_i(boot),
    .boot_select_o(bsel), .data_i(din), .data_valid_i(dv),
    .data_ready_o(rdy), .access_led_o(led));
  cbr_vme_master m (.clk_i, .data_i(vdat), .dtack_oe_i(dtk),
    .berr_oe_i(ber), .as_n_o(as_n), .ds_n_o(ds_n), .write_n_o(wn),
    .am_o(am), .adr_o(ahi));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (rdy === 1'b1) begin
      din <= din + 32'h1;
      left <= left - 1;
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic test_done();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wb(input logic [3:0] a, input logic w,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 20 && ack !== 1'b1; n++)
      @(posedge clk_i);
    r = rdat;
    cyc <= 1'b0;
    if (n == 20) begin
      fails++;
      test_done();
    end
  endtask
  task automatic bt(input int gap, input logic [33:0] e);
    logic [1:0] r;
    logic [31:0] d;
    m.beat(gap, r, d);
    chk({r, d}, e);
  endtask
  ////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    wdat = 32'h0;
    sr_n = 1'b1;
    jp = 1'b1;
    tok_n = 1'b1;
    boot = 4'hA;
    din = 32'hC0DE0000;
    left = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({32'h0, tok_o, led}, 34'h2);
    for (i = 0; i < 5; i++) begin
      wb(rows[i][67:64], 1'b1, rows[i][63:32], rd);
      wb(rows[i][67:64], 1'b0, 32'h0, rd);
      chk({2'h0, rd}, {2'h0, rows[i][31:0]});
    end
    chk({30'h0, bsel}, 34'hA);
    for (k = 0; k < 2; k++) begin
      m.start(k ? 6'h0F : 6'h0B, 8'h45, 1'b1);
      bt(8, 34'h108000000);
      chk({33'h0, led}, 34'h1);
      bt(8, 34'h108000008);
      bt(8, 34'h200000000);
      m.stop();
    end
    wb(4'h8, 1'b0, 32'h0, rd);
    chk({2'h0, rd}, 34'h8);
    wb(4'h0, 1'b1, 32'h45001807, rd);
    left <= 2;
    m.start(6'h0B, 8'h45, 1'b1);
    bt(8, 34'h118000000);
    bt(30, 34'h1C0DE0000);
    bt(8, 34'h1C0DE0001);
    bt(8, 34'h118000010);
    bt(8, 34'h200000000);
    m.stop();
    for (k = 0; k < 3; k++) begin
      m.start(k == 0 ? 6'h09 : 6'h0B, k == 1 ? 8'h46 : 8'h45, k != 2);
      bt(8, 34'h0);
      m.stop();
    end
    // middle member waits for the token, then passes it on
    wb(4'h0, 1'b1, 32'h45001001, rd);
    m.start(6'h0B, 8'h45, 1'b1);
    bt(8, 34'h0);
    tok_n <= 1'b0;
    bt(8, 34'h110000000);
    bt(8, 34'h110000008);
    bt(8, 34'h0);
    chk({33'h0, tok_o}, 34'h0);
    m.stop();
    tok_n <= 1'b1;
    wb(4'h0, 1'b1, 32'h45000807, rd);
    left <= 3;
    m.start(6'h0B, 8'h45, 1'b1);
    bt(8, 34'h108000000);
    bt(8, 34'h1C0DE0002);
    m.stop();
    m.start(6'h0B, 8'h45, 1'b1);
    bt(8, 34'h108000000);
    m.stop();
    left <= 0;
    // enable bit clear: the module stays silent at its chained address
    wb(4'h0, 1'b1, 32'h45000806, rd);
    m.start(6'h0B, 8'h45, 1'b1);
    bt(8, 34'h0);
    m.stop();
    chk({33'h0, led}, 34'h0);
    boot <= 4'h5;
    for (k = 0; k < 2; k++) begin
      jp <= (k == 0);
      sr_n <= 1'b0;
      repeat (10) @(posedge clk_i);
      sr_n <= 1'b1;
      repeat (10) @(posedge clk_i);
      wb(4'h0, 1'b0, 32'h0, rd);
      chk({2'h0, rd}, k ? 34'h0 : 34'h045000806);
    end
    chk({30'h0, bsel}, 34'h5);
    test_done();
  end
endmodule
`default_nettype wire
